// ---- shared/acr_pkg.sv ----
// shared constants and types of the converter result and control block
package acr_pkg;
    // ---------------------------------------------------------------
    // register indices; byte address is four times the index
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_RESULT_LOW  = 8'h78;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
    localparam logic [7:0] IDX_CONTROL     = 8'h7A;
    localparam logic [7:0] IDX_SELECT      = 8'h7C;
    localparam logic [7:0] IDX_INT_STATUS  = 8'h80;
    localparam logic [7:0] IDX_INT_MASK    = 8'h81;
    // ---------------------------------------------------------------
    // field positions and reset values
    // ---------------------------------------------------------------
    localparam int CTL_ENABLE = 7;
    localparam int CTL_START  = 6;
    localparam int CTL_AUTO   = 5;
    localparam int CTL_FLAG   = 4;
    localparam int CTL_IE     = 3;
    localparam int SEL_LEFT   = 5;
    localparam int INT_DONE   = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] SELECT_RESET  = 8'h00;
    localparam logic [7:0] INT_RESET     = 8'h00;
    // ---------------------------------------------------------------
    // timing in converter clock cycles
    // ---------------------------------------------------------------
    localparam logic [4:0] FIRST_CYCLES  = 5'h19;
    localparam logic [4:0] NORMAL_CYCLES = 5'h0D;
    // ---------------------------------------------------------------
    // result codes and references
    // ---------------------------------------------------------------
    localparam logic [9:0] SINGLE_MAX = 10'h3FF;
    localparam logic [9:0] SINGLE_MIN = 10'h000;
    localparam logic [9:0] DIFF_MAX   = 10'h1FF;
    localparam logic [9:0] DIFF_MIN   = 10'h200;
    localparam logic [1:0] REF_EXT_PIN  = 2'h0;
    localparam logic [1:0] REF_SUPPLY   = 2'h1;
    localparam logic [1:0] REF_INTERNAL = 2'h3;

    typedef enum logic [2:0] {
        ACR_CH_SINGLE, ACR_CH_NONE, ACR_CH_DIFF_N1, ACR_CH_DIFF_N2,
        ACR_CH_BANDGAP, ACR_CH_GROUND
    } acr_chan_kind_t;

    function automatic acr_chan_kind_t chan_kind(input logic [4:0] code);
        acr_chan_kind_t k;
        k = ACR_CH_NONE;
        case (code[4:3])
            2'b00: k = ACR_CH_SINGLE;
            2'b01: k = ACR_CH_NONE;
            2'b10: k = ACR_CH_DIFF_N1;
            default: begin
                if (code == 5'h1E) k = ACR_CH_BANDGAP;
                else if (code == 5'h1F) k = ACR_CH_GROUND;
                else k = ACR_CH_DIFF_N2;
            end
        endcase
        return k;
    endfunction
endpackage

// ---- shared/acr_conv_if.sv ----
// carrier between the control registers, the sequencer and the formatter
`timescale 1ns/1ps
`default_nettype none
interface acr_conv_if;
    logic       enable;
    logic       start;
    logic       first;
    logic       auto_run;
    logic [2:0] divider;
    logic       busy;
    logic       done;
    logic       sample;
    logic [10:0] raw;
    logic       diff;
    logic [9:0] coded;
    logic [9:0] result;
    logic       left;
    logic [7:0] low_byte;
    logic [7:0] high_byte;
    modport ctl (output enable, start, first, auto_run, divider, raw, diff, result, left,
                 input busy, done, sample, coded, low_byte, high_byte);
    modport seq (input enable, start, first, auto_run, divider, output busy, done, sample);
    modport fmt (input raw, diff, result, left, output coded, low_byte, high_byte);
endinterface
`default_nettype wire

// ---- hdl/acr_seq.sv ----
// conversion sequencer: converter clock divider and cycle counting
`timescale 1ns/1ps
`default_nettype none
module acr_seq (
    input  wire logic pclk,
    input  wire logic presetn,
    acr_conv_if.seq   cif
);
    typedef enum logic {ACR_SEQ_IDLE, ACR_SEQ_RUN} acr_seq_state_t;

    acr_seq_state_t state;
    logic [6:0]     div_cnt;
    logic [4:0]     cyc_cnt;
    logic [4:0]     cyc_last;
    logic           tick;

    // division factor minus one: codes 0 and 1 both divide by two
    function automatic logic [6:0] div_limit(input logic [2:0] code);
        logic [7:0] f;
        f = (code == 3'h0) ? 8'h02 : (8'h01 << code);
        return 7'(f - 8'h01);
    endfunction

    assign tick = (div_cnt == div_limit(cif.divider));

    // ---------------------------------------------------------------
    // converter clock: restarts with each conversion for even timing
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 7'h00;
        end else if (state == ACR_SEQ_IDLE || tick) begin
            div_cnt <= 7'h00;
        end else begin
            div_cnt <= div_cnt + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= ACR_SEQ_IDLE;
            cyc_cnt  <= 5'h00;
            cyc_last <= 5'h00;
            cif.busy <= 1'b0;
            cif.done <= 1'b0;
            cif.sample <= 1'b0;
        end else begin
            cif.done   <= 1'b0;
            cif.sample <= 1'b0;
            case (state)
                ACR_SEQ_IDLE: begin
                    if (cif.enable && cif.start) begin
                        state      <= ACR_SEQ_RUN;
                        cyc_cnt    <= 5'h01;
                        cyc_last   <= cif.first ? acr_pkg::FIRST_CYCLES
                                                : acr_pkg::NORMAL_CYCLES;
                        cif.busy   <= 1'b1;
                        cif.sample <= 1'b1;
                    end
                end
                ACR_SEQ_RUN: begin
                    if (!cif.enable) begin
                        state    <= ACR_SEQ_IDLE;
                        cif.busy <= 1'b0;
                    end else if (tick) begin
                        if (cyc_cnt == cyc_last) begin
                            cif.done <= 1'b1;
                            if (cif.auto_run) begin
                                cyc_cnt    <= 5'h01;
                                cyc_last   <= acr_pkg::NORMAL_CYCLES;
                                cif.sample <= 1'b1;
                            end else begin
                                state    <= ACR_SEQ_IDLE;
                                cif.busy <= 1'b0;
                            end
                        end else begin
                            cyc_cnt <= cyc_cnt + 5'h01;
                        end
                    end
                end
                default: begin
                    state    <= ACR_SEQ_IDLE;
                    cif.busy <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- hdl/acr_fmt.sv ----
// result coding and byte presentation
`timescale 1ns/1ps
`default_nettype none
module acr_fmt (
    acr_conv_if.fmt cif
);
    // ---------------------------------------------------------------
    // coding of the core sample
    // ---------------------------------------------------------------
    always_comb begin
        if (cif.diff) begin
            if (!cif.raw[10] && cif.raw[9]) cif.coded = acr_pkg::DIFF_MAX;
            else if (cif.raw[10] && !cif.raw[9]) cif.coded = acr_pkg::DIFF_MIN;
            else cif.coded = cif.raw[9:0];
        end else begin
            if (cif.raw[10]) cif.coded = acr_pkg::SINGLE_MIN;
            else cif.coded = cif.raw[9:0];
        end
    end

    // ---------------------------------------------------------------
    // alignment follows the bit at once, even mid conversion
    // ---------------------------------------------------------------
    always_comb begin
        if (cif.left) begin
            cif.high_byte = cif.result[9:2];
            cif.low_byte  = {cif.result[1:0], 6'h00};
        end else begin
            cif.high_byte = {6'h00, cif.result[9:8]};
            cif.low_byte  = cif.result[7:0];
        end
    end
endmodule
`default_nettype wire

// ---- hdl/acr_top.sv ----
// converter control and result registers behind an apb slave
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module acr_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        vector_ack,
    input  wire logic [10:0] core_sample,
    output logic             irq,
    output logic             analog_power,
    output logic             analog_sample,
    output logic      [4:0]  analog_channel,
    output logic      [1:0]  analog_reference,
    output logic             analog_diff,
    output logic             supply_ref_on,
    output logic             internal_ref_on
);
    acr_conv_if cif ();

    logic [7:0] control;
    logic [7:0] select;
    logic [7:0] int_status;
    logic [7:0] int_mask;
    logic [9:0] result;
    logic       result_lock;
    logic       first_pending;
    logic       start_req;
    logic       done_flag;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic       acc;
    logic       wr;
    logic       rd;
    logic [7:0] idx;
    logic       mapped;
    logic [7:0] wbyte;

    function automatic logic is_mapped(input logic [11:0] a);
        logic [7:0] i;
        i = a[9:2];
        return (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
               (i == acr_pkg::IDX_RESULT_LOW || i == acr_pkg::IDX_RESULT_HIGH ||
                i == acr_pkg::IDX_CONTROL || i == acr_pkg::IDX_SELECT ||
                i == acr_pkg::IDX_INT_STATUS || i == acr_pkg::IDX_INT_MASK);
    endfunction

    assign acc    = psel && penable && pready;
    assign wr     = acc && pwrite;
    assign rd     = acc && !pwrite;
    assign idx    = paddr[9:2];
    assign mapped = is_mapped(paddr);
    assign wbyte  = pwdata[7:0];

    // no wait state: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !is_mapped(paddr);
        end
    end

    // ---------------------------------------------------------------
    // read data, captured in the setup cycle
    // ---------------------------------------------------------------
    logic [7:0] read_byte;

    always_comb begin
        read_byte = 8'h00;
        case (paddr[9:2])
            acr_pkg::IDX_RESULT_LOW:  read_byte = cif.low_byte;
            acr_pkg::IDX_RESULT_HIGH: read_byte = cif.high_byte;
            acr_pkg::IDX_CONTROL: begin
                read_byte = control;
                read_byte[acr_pkg::CTL_START] = start_req || cif.busy;
                read_byte[acr_pkg::CTL_FLAG]  = done_flag;
            end
            acr_pkg::IDX_SELECT:     read_byte = select;
            acr_pkg::IDX_INT_STATUS: read_byte = int_status;
            acr_pkg::IDX_INT_MASK:   read_byte = int_mask;
            default:                 read_byte = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite && is_mapped(paddr)) begin
            prdata <= {24'h00_0000, read_byte};
        end else if (!psel) begin
            prdata <= 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // control register
    // ---------------------------------------------------------------
    logic wr_ctl;
    assign wr_ctl = wr && mapped && (idx == acr_pkg::IDX_CONTROL);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= acr_pkg::CONTROL_RESET;
        end else if (wr_ctl) begin
            control <= wbyte;
        end
    end

    // start is a request held until the sequencer takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_req <= 1'b0;
        end else if (wr_ctl && wbyte[acr_pkg::CTL_START] && wbyte[acr_pkg::CTL_ENABLE]) begin
            start_req <= !cif.busy;
        end else if (cif.sample || !control[acr_pkg::CTL_ENABLE]) begin
            start_req <= 1'b0;
        end
    end

    // a fresh enable makes the next conversion the long initialising one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_pending <= 1'b0;
        end else if (wr_ctl && wbyte[acr_pkg::CTL_ENABLE] && !control[acr_pkg::CTL_ENABLE]) begin
            first_pending <= 1'b1;
        end else if (cif.sample) begin
            first_pending <= 1'b0;
        end
    end

    // set wins over both clear paths
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 1'b0;
        end else if (cif.done) begin
            done_flag <= 1'b1;
        end else if (vector_ack || (wr_ctl && wbyte[acr_pkg::CTL_FLAG])) begin
            done_flag <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // selection register and the copy held by a conversion
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select <= acr_pkg::SELECT_RESET;
        end else if (wr && mapped && idx == acr_pkg::IDX_SELECT) begin
            select <= wbyte;
        end
    end

    // the copy follows the register while idle and moves again only at completion,
    // so a mid-flight change waits for completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_channel   <= 5'h00;
            analog_reference <= acr_pkg::REF_EXT_PIN;
            analog_diff      <= 1'b0;
        end else if (!cif.busy || cif.done) begin
            analog_channel   <= select[4:0];
            analog_reference <= select[7:6];
            analog_diff      <= acr_pkg::chan_kind(select[4:0]) == acr_pkg::ACR_CH_DIFF_N1 ||
                                acr_pkg::chan_kind(select[4:0]) == acr_pkg::ACR_CH_DIFF_N2;
        end
    end

    // reserved reference code leaves both sources off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_ref_on   <= 1'b0;
            internal_ref_on <= 1'b0;
        end else begin
            supply_ref_on   <= analog_reference == acr_pkg::REF_SUPPLY;
            internal_ref_on <= analog_reference == acr_pkg::REF_INTERNAL;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_power  <= 1'b0;
            analog_sample <= 1'b0;
        end else begin
            analog_power  <= control[acr_pkg::CTL_ENABLE];
            analog_sample <= cif.sample;
        end
    end

    // ---------------------------------------------------------------
    // sequencer and formatter hookup
    // ---------------------------------------------------------------
    assign cif.enable   = control[acr_pkg::CTL_ENABLE];
    assign cif.start    = start_req;
    assign cif.first    = first_pending;
    assign cif.auto_run = control[acr_pkg::CTL_AUTO];
    assign cif.divider  = control[2:0];
    assign cif.raw      = core_sample;
    assign cif.diff     = analog_diff;
    assign cif.result   = result;
    assign cif.left     = select[acr_pkg::SEL_LEFT];

    acr_seq u_seq (
        .pclk    (pclk),
        .presetn (presetn),
        .cif     (cif.seq)
    );

    acr_fmt u_fmt (
        .cif (cif.fmt)
    );

    // ---------------------------------------------------------------
    // result register and read lock
    // ---------------------------------------------------------------
    logic rd_low;
    logic rd_high;
    assign rd_low  = rd && mapped && idx == acr_pkg::IDX_RESULT_LOW;
    assign rd_high = rd && mapped && idx == acr_pkg::IDX_RESULT_HIGH;

    // a completion during the lock is dropped; only the flag and the status bit record it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= 10'h000;
        end else if (cif.done && !result_lock) begin
            result <= cif.coded;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_lock <= 1'b0;
        end else if (rd_high) begin
            result_lock <= 1'b0;
        end else if (rd_low) begin
            result_lock <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // interrupt status, mask and output
    // ---------------------------------------------------------------
    logic rd_stat;
    assign rd_stat = rd && mapped && idx == acr_pkg::IDX_INT_STATUS;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= acr_pkg::INT_RESET;
        end else begin
            int_status[7:1] <= 7'h00;
            if (cif.done) begin
                int_status[acr_pkg::INT_DONE] <= 1'b1;
            end else if (rd_stat) begin
                int_status[acr_pkg::INT_DONE] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask <= acr_pkg::INT_RESET;
        end else if (wr && mapped && idx == acr_pkg::IDX_INT_MASK) begin
            int_mask <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_mask) ||
                   (done_flag && control[acr_pkg::CTL_IE]);
        end
    end
endmodule
`default_nettype wire

// ---- sim/acr_core_model.sv ----
// stand-in for the analog core: returns the level seen at each sample pulse
`timescale 1ns/1ps
`default_nettype none
module acr_core_model (
    input  wire logic        pclk,
    input  wire logic        analog_power,
    input  wire logic        analog_sample,
    input  wire logic [10:0] level,
    output logic      [10:0] core_sample
);
    // powered down the code wanders: no stale result
    always_ff @(posedge pclk) begin
        if (analog_sample) begin
            core_sample <= level;
        end else if (!analog_power) begin
            core_sample <= ~core_sample;
        end
    end
endmodule
`default_nettype wire

// ---- sim/acr_top_sva.sv ----
// concurrent checks on the ports of the converter control block
`timescale 1ns/1ps
`default_nettype none
module acr_top_sva (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        analog_power,
    input  wire logic        analog_sample,
    input  wire logic [4:0]  analog_channel,
    input  wire logic [1:0]  analog_reference,
    input  wire logic        analog_diff,
    input  wire logic        supply_ref_on,
    input  wire logic        internal_ref_on
);
    localparam logic [11:0] A_CTL = {2'h0, acr_pkg::IDX_CONTROL, 2'h0};
    logic wr_ctl;
    logic en_q;
    assign wr_ctl = psel && penable && pready && pwrite && paddr == A_CTL;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
        end else if (wr_ctl) begin
            en_q <= pwdata[7];
        end
    end
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    // shortest conversion is 13 ticks of at least two clocks each
    sequence s_quiet;
        !analog_sample [*8];
    endsequence
    AST_READY: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_SLVERR: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error with data");
    AST_POWER: assert property (wr_ctl |-> ##2 analog_power == en_q)
        else $error("power not enable");
    AST_SAMPLE_ON: assert property (analog_sample |-> analog_power)
        else $error("sample while off");
    AST_SPACING: assert property (analog_sample |=> s_quiet)
        else $error("conversion too short");
    AST_REFS: assert property (supply_ref_on == ($past(analog_reference) == 2'h1)
        && internal_ref_on == ($past(analog_reference) == 2'h3)) else $error("reference mismatch");
    AST_DIFF: assert property (analog_diff == (analog_channel inside {[5'h10:5'h1D]}))
        else $error("pair flag mismatch");
endmodule
`default_nettype wire

// ---- sim/acr_top_tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acr_top_tb;
    localparam logic [11:0] A_LO  = {2'h0, acr_pkg::IDX_RESULT_LOW, 2'h0};
    localparam logic [11:0] A_HI  = {2'h0, acr_pkg::IDX_RESULT_HIGH, 2'h0};
    localparam logic [11:0] A_CTL = {2'h0, acr_pkg::IDX_CONTROL, 2'h0};
    localparam logic [11:0] A_SEL = {2'h0, acr_pkg::IDX_SELECT, 2'h0};
    localparam logic [11:0] A_ST  = {2'h0, acr_pkg::IDX_INT_STATUS, 2'h0};
    localparam logic [11:0] A_MK  = {2'h0, acr_pkg::IDX_INT_MASK, 2'h0};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, vack, er;
    logic        pwr, smp, diff, sup, intr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [10:0] level, core_sample;
    logic [4:0]  chan;
    logic [1:0]  refs;
    logic [7:0]  r;
    int          num_errors, cmp_count, t0, t;
    int          cyc = 0;
    acr_top acr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vector_ack(vack), .core_sample(core_sample), .irq(irq),
        .analog_power(pwr), .analog_sample(smp), .analog_channel(chan),
        .analog_reference(refs), .analog_diff(diff), .supply_ref_on(sup),
        .internal_ref_on(intr));
    acr_core_model acr_core_model_i (.pclk(pclk), .analog_power(pwr), .analog_sample(smp),
        .level(level), .core_sample(core_sample));
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        {psel, penable, pwrite} <= {2'b10, w};
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata[7:0];
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [11:0] a, input string n, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(n, r, e);
    endtask
    task automatic start(input logic [10:0] lv, input logic [7:0] c);
        level <= lv;
        apb(1'b1, A_CTL, c);
        t0 = cyc;
    endtask
    task automatic wait_done();
        while (irq !== 1'b1) @(posedge pclk);
        t = cyc - t0;
        rd(A_ST, "status", 8'h01);
    endtask
    task automatic t_regs();
        rd(A_CTL, "ctl_rst", acr_pkg::CONTROL_RESET);
        rd(A_SEL, "sel_rst", acr_pkg::SELECT_RESET);
        rd(12'h3FC, "unmapped", 8'h00);
        chk("slverr", er, 1'b1);
        apb(1'b1, A_SEL, 8'h9E);
        rd(A_SEL, "sel_rsvd", 8'h9E);
        chk("refs_off", {sup, intr}, 2'b00);
        for (int c = 0; c < 32; c++) begin
            apb(1'b1, A_SEL, {3'h7, c[4:0]});
            repeat (3) @(posedge pclk);
            chk("chan", chan, c[4:0]);
            chk("diff", diff, c >= 16 && c <= 29);
        end
        chk("internal", {sup, intr}, 2'b01);
        apb(1'b1, A_SEL, 8'h40);
        repeat (3) @(posedge pclk);
        chk("supply", {sup, intr}, 2'b10);
        $display("done: registers");
    endtask
    task automatic t_first();
        apb(1'b1, A_MK, 8'h01);
        apb(1'b1, A_SEL, 8'h03);
        start(11'h155, 8'hC0);
        rd(A_CTL, "busy", 8'hC0);
        wait_done();
        chk("first_len", t >= 50 && t <= 58, 1'b1);
        rd(A_CTL, "flag", 8'h90);
        rd(A_LO, "lo", 8'h55);
        rd(A_HI, "hi", 8'h01);
        vack <= 1'b1;
        @(posedge pclk);
        vack <= 1'b0;
        rd(A_CTL, "flag_vec", 8'h80);
        start(11'h3FF, 8'hC0);
        wait_done();
        chk("next_len", t >= 26 && t <= 34, 1'b1);
        $display("done: first");
    endtask
    task automatic t_format();
        logic [7:0]  s [4] = '{8'hDB, 8'hDB, 8'h00, 8'h40};
        logic [10:0] v [4] = '{11'h2FF, 11'h500, 11'h7FF, 11'h3FF};
        logic [9:0]  e [4] = '{10'h1FF, 10'h200, 10'h000, 10'h3FF};
        apb(1'b1, A_SEL, 8'hFB);
        start(11'h7A3, 8'hC0);
        wait_done();
        rd(A_LO, "left_lo", 8'hC0);
        rd(A_HI, "left_hi", 8'hE8);
        apb(1'b1, A_SEL, 8'hDB);
        rd(A_LO, "right_lo", 8'hA3);
        rd(A_HI, "right_hi", 8'h03);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, A_SEL, s[i]);
            start(v[i], 8'hC0);
            wait_done();
            rd(A_LO, "code_lo", e[i][7:0]);
            rd(A_HI, "code_hi", {6'h00, e[i][9:8]});
        end
        $display("done: format");
    endtask
    task automatic t_hold();
        apb(1'b1, A_SEL, 8'h43);
        start(11'h100, 8'hC0);
        apb(1'b1, A_SEL, 8'h45);
        chk("held_chan", chan, 5'h03);
        apb(1'b1, A_CTL, 8'h80);
        rd(A_CTL, "start_kept", 8'hD0);
        wait_done();
        repeat (3) @(posedge pclk);
        chk("new_chan", chan, 5'h05);
        apb(1'b1, A_CTL, 8'h90);
        rd(A_CTL, "flag_w1c", 8'h80);
        apb(1'b1, A_SEL, 8'h00);
        start(11'h155, 8'hC0);
        wait_done();
        rd(A_LO, "lock_lo", 8'h55);
        start(11'h2AA, 8'hC0);
        wait_done();
        rd(A_HI, "lock_hi", 8'h01);
        $display("done: hold");
    endtask
    task automatic t_abort();
        start(11'h100, 8'hC0);
        repeat (10) @(posedge pclk);
        apb(1'b1, A_CTL, 8'h00);
        repeat (80) @(posedge pclk);
        chk("no_irq", irq, 1'b0);
        rd(A_CTL, "off", 8'h10);
        start(11'h100, 8'hC0);
        wait_done();
        chk("first_again", t >= 50 && t <= 58, 1'b1);
        apb(1'b1, A_MK, 8'h00);
        start(11'h100, 8'hC0);
        repeat (40) @(posedge pclk);
        chk("masked", irq, 1'b0);
        rd(A_ST, "st_set", 8'h01);
        rd(A_ST, "st_clr", 8'h00);
        apb(1'b1, A_CTL, 8'h88);
        repeat (2) @(posedge pclk);
        chk("ie_irq", irq, 1'b1);
        apb(1'b1, A_CTL, 8'h90);
        repeat (2) @(posedge pclk);
        chk("ie_clr", irq, 1'b0);
        $display("done: abort");
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        {psel, penable, pwrite, vack, presetn} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        level = 11'h000;
        num_errors = 0;
        cmp_count = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_first();
        t_format();
        t_hold();
        t_abort();
        tally_and_finish();
    end
endmodule
bind acr_top acr_top_sva acr_top_sva_i (.*);
`default_nettype wire
